// ---- smu_pkg.sv ----
// constants shared by the serial master unit: register indices, field positions,
// reset values, trigger codes and engine states.
// assumes a register host that writes each transmit word in a single access.
// What this block does
// (R1) a transfer leaves the received bits in a 64-bit rx word; unused top bits mean nothing.
// (R2) a 64-bit tx word goes out on the next transfer; bits above the length are ignored.
// (R3) in write-start mode a transfer begins once the top byte given by the length is written.
// (R4) the host writes a whole tx word in one access so no transfer sees a partial word.
// (R5) setup holds a two-bit slave select and bits for lsb-first, clock phase and clock polarity.
// (R6) with keep-select set, select stays low after a transfer so a longer datagram can go on.
// (R7) a 3-bit field picks the start: write, pwm start, centre, mark a, mark b, both, single.
// (R8) with the single code, setting setup bit 15 starts exactly one transfer.
// (R9) status bit 0 shows the last transfer done and ready, the other 63 bits read zero.
// (R10) a six-bit length field holds the datagram size in bits minus one.
// (R11) an eight-bit divider d makes the serial clock the base clock over four plus two times d.
// (R12) done is low during a transfer and set once the last bit is shifted and the word stored.
// (R13) a transfer pulls its select low, gives one clock per bit and samples per cpha and cpol.
package smu_pkg;
  localparam logic [6:0]  REG_RX_WORD    = 7'h06;
  localparam logic [6:0]  REG_TX_WORD    = 7'h07;
  localparam logic [6:0]  REG_SETUP      = 7'h08;
  localparam logic [6:0]  REG_STATE      = 7'h09;
  localparam logic [6:0]  REG_SIZE       = 7'h0a;
  localparam logic [6:0]  REG_PERIOD     = 7'h0b;
  localparam int          SETUP_SEL_LO   = 0;
  localparam int          SETUP_KEEP     = 3;
  localparam int          SETUP_LSB      = 4;
  localparam int          SETUP_CPHA     = 5;
  localparam int          SETUP_CPOL     = 6;
  localparam int          SETUP_TRIG_LO  = 8;
  localparam int          SETUP_ONESHOT  = 15;
  localparam int          STATE_DONE     = 0;
  localparam logic [15:0] SETUP_RESET    = 16'h0000;
  localparam logic [5:0]  SIZE_RESET     = 6'h07;
  localparam logic [7:0]  PERIOD_RESET   = 8'h00;
  localparam logic [8:0]  HALF_BASE      = 9'h002;
  localparam logic [2:0]  TRIG_WRITE     = 3'h0;
  localparam logic [2:0]  TRIG_PWM_START = 3'h1;
  localparam logic [2:0]  TRIG_PWM_MID   = 3'h2;
  localparam logic [2:0]  TRIG_MARK_A    = 3'h3;
  localparam logic [2:0]  TRIG_MARK_B    = 3'h4;
  localparam logic [2:0]  TRIG_MARK_AB   = 3'h5;
  localparam logic [2:0]  TRIG_SINGLE    = 3'h7;
  typedef enum logic [1:0] {
    SMU_IDLE  = 2'b00,
    SMU_SHIFT = 2'b01,
    SMU_STORE = 2'b10
  } smu_state_t;
endpackage

// ---- smu_slave_model.sv ----
// slave model: mode 0, msb first, answers with i_reply.
// assumes select stays low for one whole datagram.
`timescale 1ns/1ps
`default_nettype none
module smu_slave_model (
  // serial pins
  input  wire logic        i_sclk,
  input  wire logic        i_select_n,
  input  wire logic        i_mosi,
  output logic             o_miso,
  // datagram
  input  wire logic [63:0] i_reply,
  input  wire logic [5:0]  i_len,
  output logic      [63:0] o_heard
);
  int idx;
  initial o_miso = 1'b0;
  always @(negedge i_select_n) begin
    idx = i_len;
    o_miso = i_reply[idx];
    o_heard = '0;
  end
  always @(posedge i_sclk) if (!i_select_n) o_heard = {o_heard[62:0], i_mosi};
  always @(negedge i_sclk) if (!i_select_n && idx > 0) begin
    idx = idx - 1;
    o_miso = i_reply[idx];
  end
  // a released line flips so a late sample cannot match by luck
  always @(posedge i_select_n) o_miso = ~o_miso;
endmodule // smu_slave_model
`default_nettype wire

// ---- smu_spi_master_unit.sv ----
// serial master engine with its register set and a two-entry receive stream buffer.
// assumes one clock, inputs synchronous to it, pwm events as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module smu_spi_master_unit (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  // register access
  input  wire logic        i_reg_write,
  input  wire logic        i_reg_read,
  input  wire logic [6:0]  i_reg_index,
  input  wire logic [63:0] i_reg_wdata,
  input  wire logic [7:0]  i_reg_wbytes,
  output logic      [63:0] o_reg_rdata,
  output logic             o_reg_rvalid,
  // pwm events
  input  wire logic        i_pwm_cycle_start,
  input  wire logic        i_pwm_cycle_centre,
  input  wire logic        i_pwm_mark_a,
  input  wire logic        i_pwm_mark_b,
  // serial pins
  output logic             o_sclk,
  output logic             o_mosi,
  output logic      [3:0]  o_select_n,
  input  wire logic        i_miso,
  // received word stream
  output logic             o_rx_valid,
  output logic      [63:0] o_rx_data,
  input  wire logic        i_rx_ready
);
  function automatic logic [63:0] smu_merge(input logic [63:0] old_v,
                                            input logic [63:0] new_v,
                                            input logic [7:0]  be);
    logic [63:0] r;
    r = old_v;
    for (int b = 0; b < 8; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  smu_pkg::smu_state_t state_reg;
  logic [15:0] setup_reg;
  logic [5:0]  size_reg;
  logic [7:0]  period_reg;
  logic [63:0] tx_word_reg;
  logic [63:0] rx_word_reg;
  logic        done_reg;
  logic        pending_reg;
  logic [63:0] tx_shift_reg;
  logic [63:0] rx_shift_reg;
  logic [5:0]  bit_reg;
  logic [8:0]  half_reg;
  logic        lead_reg;
  logic [63:0] fifo1_reg;
  logic [1:0]  fifo_count_reg;

  logic [2:0]  trig;
  logic        wr_tx;
  logic        wr_setup;
  logic        fire;
  logic        start;
  logic        half_end;
  logic        last_bit;
  logic        cpha;
  logic        lsb_first;
  logic        sample_now;
  logic        drive_now;
  logic        push;
  logic        pop;
  logic        tx_bit;
  logic [63:0] tx_load;

  assign trig      = setup_reg[smu_pkg::SETUP_TRIG_LO +: 3];
  assign cpha      = setup_reg[smu_pkg::SETUP_CPHA];
  assign lsb_first = setup_reg[smu_pkg::SETUP_LSB];
  assign wr_tx     = i_reg_write && (i_reg_index == smu_pkg::REG_TX_WORD);
  assign wr_setup  = i_reg_write && (i_reg_index == smu_pkg::REG_SETUP);
  // a write taken at the start edge must go out, so the engine loads the merged word
  assign tx_load   = wr_tx ? smu_merge(tx_word_reg, i_reg_wdata, i_reg_wbytes) // R2
                           : tx_word_reg;

  // pick the start source
  always_comb begin
    unique case (trig)
      smu_pkg::TRIG_WRITE:     fire = wr_tx && i_reg_wbytes[size_reg[5:3]]; // R3 R4
      smu_pkg::TRIG_PWM_START: fire = i_pwm_cycle_start; // R7
      smu_pkg::TRIG_PWM_MID:   fire = i_pwm_cycle_centre; // R7
      smu_pkg::TRIG_MARK_A:    fire = i_pwm_mark_a; // R7
      smu_pkg::TRIG_MARK_B:    fire = i_pwm_mark_b; // R7
      smu_pkg::TRIG_MARK_AB:   fire = i_pwm_mark_a || i_pwm_mark_b; // R7
      smu_pkg::TRIG_SINGLE:    fire = setup_reg[smu_pkg::SETUP_ONESHOT]; // R8
      default:                 fire = 1'b0;
    endcase
  end

  assign start      = (state_reg == smu_pkg::SMU_IDLE) && (pending_reg || fire);
  assign half_end   = (half_reg == 9'h000);
  // the bit counter wraps after 64 bits, so a full-length datagram needs no wider count
  assign last_bit   = (bit_reg == size_reg);
  assign sample_now = (state_reg == smu_pkg::SMU_SHIFT) && half_end && (lead_reg != cpha);
  assign drive_now  = (state_reg == smu_pkg::SMU_SHIFT) && half_end &&
                      (cpha ? lead_reg : (!lead_reg && !last_bit));
  assign tx_bit     = lsb_first ? tx_shift_reg[0] : tx_shift_reg[size_reg]; // R2
  // a full buffer stalls the store, so a slow receiver costs time, never a word
  assign push       = (state_reg == smu_pkg::SMU_STORE) && (fifo_count_reg != 2'h2);
  assign pop        = o_rx_valid && i_rx_ready;

  // register file
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      setup_reg   <= smu_pkg::SETUP_RESET;
      size_reg    <= smu_pkg::SIZE_RESET;
      period_reg  <= smu_pkg::PERIOD_RESET;
      tx_word_reg <= 64'h0;
    end else begin
      if (wr_tx) begin
        tx_word_reg <= smu_merge(tx_word_reg, i_reg_wdata, i_reg_wbytes); // R2
      end
      // a software write wins over the self-clear so a re-arm in that cycle is kept
      if (wr_setup) begin
        if (i_reg_wbytes[0]) begin
          setup_reg[7:0] <= i_reg_wdata[7:0]; // R5
        end
        if (i_reg_wbytes[1]) begin
          setup_reg[15:8] <= i_reg_wdata[15:8]; // R5
        end
      end else if (start && trig == smu_pkg::TRIG_SINGLE) begin
        setup_reg[smu_pkg::SETUP_ONESHOT] <= 1'b0; // R8
      end
      if (i_reg_write && i_reg_index == smu_pkg::REG_SIZE && i_reg_wbytes[0]) begin
        size_reg <= i_reg_wdata[5:0]; // R10
      end
      if (i_reg_write && i_reg_index == smu_pkg::REG_PERIOD && i_reg_wbytes[0]) begin
        period_reg <= i_reg_wdata[7:0]; // R11
      end
    end
  end

  // register read, one cycle after the request
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata  <= 64'h0;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_read;
      if (i_reg_read) begin
        unique case (i_reg_index)
          smu_pkg::REG_RX_WORD: o_reg_rdata <= rx_word_reg; // R1
          smu_pkg::REG_SETUP:   o_reg_rdata <= {48'h0, setup_reg}; // R5
          smu_pkg::REG_STATE:   o_reg_rdata <= {63'h0, done_reg}; // R9
          default:              o_reg_rdata <= 64'h0;
        endcase
      end
    end
  end

  // start request held while a transfer runs so no write start is lost
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pending_reg <= 1'b0;
    end else if (state_reg == smu_pkg::SMU_IDLE) begin
      pending_reg <= 1'b0;
    end else if (fire && trig == smu_pkg::TRIG_WRITE) begin
      pending_reg <= 1'b1; // R3
    end
  end

  // transfer engine
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg    <= smu_pkg::SMU_IDLE;
      done_reg     <= 1'b1;
      tx_shift_reg <= 64'h0;
      rx_shift_reg <= 64'h0;
      rx_word_reg  <= 64'h0;
      bit_reg      <= 6'h00;
      half_reg     <= 9'h000;
      lead_reg     <= 1'b1;
    end else begin
      unique case (state_reg)
        smu_pkg::SMU_IDLE: begin
          if (start) begin
            state_reg    <= smu_pkg::SMU_SHIFT;
            done_reg     <= 1'b0; // R12
            tx_shift_reg <= tx_load; // R2
            rx_shift_reg <= 64'h0;
            bit_reg      <= 6'h00;
            lead_reg     <= 1'b1;
            // the count includes zero, so one less than the half period is loaded
            half_reg     <= smu_pkg::HALF_BASE + {1'b0, period_reg} - 9'h001; // R11
          end
        end
        smu_pkg::SMU_SHIFT: begin
          if (half_end) begin
            half_reg <= smu_pkg::HALF_BASE + {1'b0, period_reg} - 9'h001; // R11
            lead_reg <= !lead_reg;
            if (!lead_reg) begin
              bit_reg <= bit_reg + 6'h01; // R13
              if (last_bit) begin
                state_reg <= smu_pkg::SMU_STORE;
              end
            end
          end else begin
            half_reg <= half_reg - 9'h001;
          end
          if (sample_now) begin
            if (lsb_first) begin
              rx_shift_reg <= (rx_shift_reg >> 1) | ({63'h0, i_miso} << size_reg); // R13
            end else begin
              rx_shift_reg <= {rx_shift_reg[62:0], i_miso}; // R13
            end
          end
          if (drive_now || (start && !cpha)) begin
            tx_shift_reg <= lsb_first ? (tx_shift_reg >> 1) : (tx_shift_reg << 1);
          end
        end
        smu_pkg::SMU_STORE: begin
          // a full stream buffer holds the engine here, so no word is lost
          if (push) begin
            rx_word_reg <= rx_shift_reg; // R1
            done_reg    <= 1'b1; // R12 R9
            state_reg   <= smu_pkg::SMU_IDLE;
          end
        end
        default: state_reg <= smu_pkg::SMU_IDLE;
      endcase
      if (state_reg == smu_pkg::SMU_IDLE && start && !cpha) begin
        tx_shift_reg <= lsb_first ? (tx_load >> 1) : (tx_load << 1);
      end
    end
  end

  // serial pins
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sclk     <= 1'b0;
      o_mosi     <= 1'b0;
      o_select_n <= 4'hf;
    end else begin
      if (state_reg == smu_pkg::SMU_IDLE) begin
        o_sclk <= setup_reg[smu_pkg::SETUP_CPOL]; // R5
        if (start) begin
          o_select_n <= ~(4'h1 << setup_reg[smu_pkg::SETUP_SEL_LO +: 2]); // R13 R5
          if (!cpha) begin
            o_mosi <= lsb_first ? tx_load[0] : tx_load[size_reg]; // R13
          end
        end else if (!setup_reg[smu_pkg::SETUP_KEEP]) begin
          o_select_n <= 4'hf; // R6
        end
      end else if (state_reg == smu_pkg::SMU_SHIFT && half_end) begin
        // the last trailing edge is kept, a phase-1 slave takes its final bit on it
        o_sclk <= !o_sclk; // R13
      end
      if (drive_now) begin
        o_mosi <= tx_bit; // R13
      end
    end
  end

  // two-entry receive stream buffer, head entry drives the port
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rx_valid     <= 1'b0;
      o_rx_data      <= 64'h0;
      fifo1_reg      <= 64'h0;
      fifo_count_reg <= 2'h0;
    end else begin
      unique case ({push, pop})
        2'b10: begin
          fifo_count_reg <= fifo_count_reg + 2'h1;
          if (fifo_count_reg == 2'h0) begin
            o_rx_data <= rx_shift_reg;
          end else begin
            fifo1_reg <= rx_shift_reg;
          end
          o_rx_valid <= 1'b1;
        end
        2'b01: begin
          fifo_count_reg <= fifo_count_reg - 2'h1;
          o_rx_data      <= fifo1_reg;
          o_rx_valid     <= (fifo_count_reg == 2'h2);
        end
        2'b11: begin
          if (fifo_count_reg == 2'h1) begin
            o_rx_data <= rx_shift_reg;
          end else begin
            o_rx_data <= fifo1_reg;
            fifo1_reg <= rx_shift_reg;
          end
        end
        default: begin
        end
      endcase
    end
  end
endmodule // smu_spi_master_unit
`default_nettype wire

// ---- smu_spi_master_unit_props.sv ----
// port assertions for the serial master unit.
// assumes one clock and an async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module smu_props_chk (
  // watched ports
  input wire logic        i_clock,
  input wire logic        i_resetn,
  input wire logic        i_reg_write,
  input wire logic        i_reg_read,
  input wire logic [6:0]  i_reg_index,
  input wire logic [63:0] o_reg_rdata,
  input wire logic        o_reg_rvalid,
  input wire logic        o_sclk,
  input wire logic [3:0]  o_select_n,
  input wire logic        o_rx_valid,
  input wire logic [63:0] o_rx_data,
  input wire logic        i_rx_ready
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  rvalid_pulse_a: assert property (i_reg_read |=> o_reg_rvalid) else $error("read unanswered");
  rvalid_only_a: assert property (!i_reg_read |=> !o_reg_rvalid) else $error("stray valid");
  rdata_hold_a: assert property (!i_reg_read |=> $stable(o_reg_rdata)) else $error("rdata moved");
  state_zero_a: assert property (i_reg_read && i_reg_index == smu_pkg::REG_STATE
    |=> o_reg_rdata[63:1] == '0) else $error("status upper bits set");
  tx_unread_a: assert property (i_reg_read && i_reg_index == smu_pkg::REG_TX_WORD
    |=> o_reg_rdata == '0) else $error("tx word readable");
  one_select_a: assert property ($countones(~o_select_n) <= 1) else $error("two selects");
  sclk_idle_a: assert property (&o_select_n && !i_reg_write && !$past(i_reg_write)
    |=> $stable(o_sclk)) else $error("sclk moved while idle");
  rx_hold_a: assert property (o_rx_valid && !i_rx_ready
    |=> o_rx_valid && $stable(o_rx_data)) else $error("stream word lost");
  xfer_c: cover property ($fell(&o_select_n));
  pop_c: cover property (o_rx_valid && i_rx_ready);
  state_c: cover property (i_reg_read && i_reg_index == smu_pkg::REG_STATE);
endmodule // smu_props_chk
bind smu_spi_master_unit smu_props_chk u_smu_props_chk (.i_clock(i_clock),
  .i_resetn(i_resetn), .i_reg_write(i_reg_write), .i_reg_read(i_reg_read),
  .i_reg_index(i_reg_index), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
  .o_sclk(o_sclk), .o_select_n(o_select_n), .o_rx_valid(o_rx_valid),
  .o_rx_data(o_rx_data), .i_rx_ready(i_rx_ready));
`default_nettype wire

// ---- test_spi_master_unit.sv ----
// bench: register task sequences against the slave model.
// assumes smu_pkg and the unit are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_spi_master_unit;
  localparam logic [6:0] RX = smu_pkg::REG_RX_WORD, TX = smu_pkg::REG_TX_WORD;
  localparam logic [6:0] SU = smu_pkg::REG_SETUP, ST = smu_pkg::REG_STATE;
  logic        i_clock = 1'b0, i_resetn = 1'b0, i_reg_write = 1'b0, i_reg_read = 1'b0;
  logic [6:0]  i_reg_index = '0;
  logic [63:0] i_reg_wdata = '0, rd_v, heard, o_reg_rdata, o_rx_data;
  logic [63:0] reply = 64'hc3a5_5a3c_0ff0_9669;
  logic [7:0]  i_reg_wbytes = '0;
  logic [5:0]  len = 6'h07;
  logic [3:0]  pwm = '0, o_select_n;
  logic        i_rx_ready = 1'b1, o_reg_rvalid, o_sclk, o_mosi, miso, o_rx_valid;
  int          err_count = 0, n_compared = 0, starts = 0, n;
  time         t0;
  always #50 i_clock = ~i_clock;
  always @(negedge (&o_select_n)) starts++;
  smu_spi_master_unit u_smu_spi_master_unit (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_reg_write(i_reg_write), .i_reg_read(i_reg_read), .i_reg_index(i_reg_index),
    .i_reg_wdata(i_reg_wdata), .i_reg_wbytes(i_reg_wbytes), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .i_pwm_cycle_start(pwm[0]), .i_pwm_cycle_centre(pwm[1]),
    .i_pwm_mark_a(pwm[2]), .i_pwm_mark_b(pwm[3]), .o_sclk(o_sclk), .o_mosi(o_mosi),
    .o_select_n(o_select_n), .i_miso(miso), .o_rx_valid(o_rx_valid),
    .o_rx_data(o_rx_data), .i_rx_ready(i_rx_ready));
  smu_slave_model u_smu_slave_model (.i_sclk(o_sclk), .i_select_n(&o_select_n),
    .i_mosi(o_mosi), .o_miso(miso), .i_reply(reply), .i_len(len), .o_heard(heard));
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] idx, input logic [63:0] d, input logic [7:0] be);
    @(posedge i_clock) #10;
    i_reg_index = idx;
    i_reg_wdata = d;
    i_reg_wbytes = be;
    i_reg_write = 1'b1;
    @(posedge i_clock) #10;
    i_reg_write = 1'b0;
  endtask
  task automatic rd(input logic [6:0] idx);
    @(posedge i_clock) #10;
    i_reg_index = idx;
    i_reg_read = 1'b1;
    @(posedge i_clock) #10;
    i_reg_read = 1'b0;
    rd_v = o_reg_rdata;
  endtask
  // polls the done flag; a hang shows up as a failed compare
  task automatic xfer_wait();
    rd_v = '0;
    repeat (4) @(posedge i_clock);
    for (int k = 0; k < 200 && rd_v[0] !== 1'b1; k++) rd(ST);
    chk("done", rd_v[0], 1'b1);
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clock);
    err_count++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge i_clock);
    #10 i_resetn = 1'b1;
    rd(ST);
    chk("state", rd_v, 64'h1);
    rd(TX);
    chk("tx read", rd_v, '0);
    wr(TX, 64'hffff_ff5a, 8'h01);
    xfer_wait();
    chk("mosi8", heard[7:0], 8'h5a);
    rd(RX);
    chk("rx8", rd_v[7:0], reply[7:0]);
    len = 6'h0f;
    wr(smu_pkg::REG_SIZE, 64'hf, 8'h01);
    wr(smu_pkg::REG_PERIOD, 64'h1, 8'h01);
    n = starts;
    wr(TX, 64'h1234, 8'h01);
    repeat (20) @(posedge i_clock);
    chk("early", starts, n);
    wr(TX, 64'h9abc, 8'h02);
    @(posedge o_sclk) t0 = $time;
    @(posedge o_sclk) chk("period", $time - t0, (smu_pkg::HALF_BASE + 64'h1) * 200);
    rd(ST);
    chk("busy", rd_v[0], 1'b0);
    xfer_wait();
    chk("mosi16", heard[15:0], 16'h9a34);
    rd(RX);
    chk("rx16", rd_v[15:0], reply[15:0]);
    wr(SU, 64'h1a, 8'h03);
    wr(TX, 64'hc1, 8'h03);
    repeat (8) @(posedge i_clock);
    chk("select", o_select_n, 4'hb);
    xfer_wait();
    chk("keep", o_select_n, 4'hb);
    chk("lsb", heard[15:0], 16'h8300);
    wr(SU, '0, 8'h03);
    wr(TX, '0, 8'h03);
    xfer_wait();
    chk("release", o_select_n, 4'hf);
    for (int c = 1; c < 8; c++) begin
      n = starts;
      wr(SU, (64'(c) << 8) | (c == 7 ? 64'h8000 : 64'h0), 8'h03);
      @(posedge i_clock) #10;
      if (c < 6) pwm = (c == 5) ? 4'b1100 : 4'b0001 << (c - 1);
      @(posedge i_clock) #10;
      pwm = '0;
      xfer_wait();
      repeat (30) @(posedge i_clock);
      chk("starts", starts, n + (c != 6));
    end
    // mode 3 shares the model's edges, so the shifted-out word must still arrive whole
    wr(SU, 64'h60, 8'h03);
    rd(SU);
    chk("setup", rd_v, 64'h60);
    chk("cpol idle", o_sclk, 1'b1);
    wr(TX, 64'h5a3c, 8'h03);
    xfer_wait();
    chk("mode3", heard[15:0], 16'h5a3c);
    // receiver stalls: two words buffered, the third transfer must wait
    i_rx_ready = 1'b0;
    wr(SU, '0, 8'h03);
    for (int k = 0; k < 3; k++) begin
      reply = 64'h10 + k;
      wr(TX, '0, 8'h03);
      repeat (120) @(posedge i_clock);
    end
    rd(ST);
    chk("held", rd_v[0], 1'b0);
    for (int k = 0; k < 3; k++) begin
      chk("stream", {o_rx_valid, o_rx_data[15:0]}, 17'h10010 + k);
      i_rx_ready = 1'b1;
      @(posedge i_clock) #10;
      i_rx_ready = 1'b0;
      repeat (150) @(posedge i_clock);
      #10;
    end
    complete_run();
  end
endmodule // test_spi_master_unit
`default_nettype wire
